// ==== shared/timer_cfg.svh ====
`ifndef TIMER_CFG_SVH
`define TIMER_CFG_SVH

// ======================================================================
// Register map
`define ADDR_A_CTRL 12'h000
`define ADDR_A_COUNT 12'h004
`define ADDR_B_CTRL0 12'h010
`define ADDR_B_COUNT0 12'h020
`define ADDR_MODE 12'h030

// ======================================================================
// Control field positions
`define BIT_ENABLE 15
`define BIT_IDLE_STOP 13
`define BIT_WBLOCK 12
`define BIT_WPEND 11
`define BIT_GATE 7
`define BIT_PS_LO 4
`define BIT_WIDE 3
`define BIT_SYNC 2
`define BIT_CLKSRC 1

// ======================================================================
// Writable masks and reset values
`define MASK_A_CTRL 32'h0000_B0B6
`define MASK_B_CTRL_EVEN 32'h0000_A0FA
`define MASK_B_CTRL_ODD 32'h0000_A0F2
`define RESET_CTRL 32'h0000_0000

// ======================================================================
// Asynchronous count write latency in Type A external clock edges
`define ASYNC_WRITE_EDGES 3'h2

`endif

// ==== shared/timer_pkg.sv ====
package timer_pkg;

  typedef struct packed {
    logic enable;
    logic gate;
    logic ext;
    logic [2:0] ps;
  } tmr_cfg_t;

  typedef enum logic [1:0] {
    WR_IDLE = 2'b00,
    WR_WAIT = 2'b01
  } wr_state_t;

endpackage

// ==== rtl/timer_prescale.sv ====
`timescale 1ns/1ps
`include "timer_cfg.svh"

// ======================================================================
// Prescaler: one tick per N input events, N a power of two.
module timer_prescale (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic event_in,
  input wire logic [3:0] log2_div,
  output logic tick
);

  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic [7:0] limit;

  always_comb
  begin
    limit = 8'hFF >> (4'h8 - log2_div);
    cnt_d = cnt_q;
    tick = 1'b0;
    if (!run)
    begin
      cnt_d = 8'h00;
    end
    else if (event_in)
    begin
      if (cnt_q >= limit)
      begin
        cnt_d = 8'h00;
        tick = 1'b1;
      end
      else
      begin
        cnt_d = cnt_q + 8'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_q <= 8'h00;
    else
      cnt_q <= cnt_d;
  end

endmodule

// ==== rtl/timer_block.sv ====
`timescale 1ns/1ps
`include "timer_cfg.svh"

module timer_block (
  input wire logic CORE_CLK,
  input wire logic RSTN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic IDLE_MODE,
  input wire logic TYPE_A_EXT_CLOCK_PIN,
  input wire logic TYPE_A_GATE_PIN,
  input wire logic [3:0] TYPE_B_EXT_CLOCK_PIN,
  input wire logic [3:0] TYPE_B_GATE_PIN
);

  // ======================================================================
  // Pin synchronisers
  logic [9:0] pin_s1_q;
  logic [9:0] pin_s2_q;
  logic [9:0] pin_s3_q;
  logic [9:0] pin_raw;
  logic idle_s1_q;
  logic idle_q;

  assign pin_raw = {TYPE_B_GATE_PIN, TYPE_B_EXT_CLOCK_PIN,
                    TYPE_A_GATE_PIN, TYPE_A_EXT_CLOCK_PIN};

  always_ff @(posedge CORE_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      pin_s1_q <= 10'h000;
      pin_s2_q <= 10'h000;
      pin_s3_q <= 10'h000;
      idle_s1_q <= 1'b0;
      idle_q <= 1'b0;
    end
    else
    begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      idle_s1_q <= IDLE_MODE;
      idle_q <= idle_s1_q;
    end
  end

  // Rising edges of synchronised pins 0 to 4 (Type A clock, Type A gate, Type B clocks 0 to 2); index 0 is Type A.
  logic [4:0] ext_rise;
  logic [4:0] gate_lvl;
  assign ext_rise = pin_s2_q[4:0] & ~pin_s3_q[4:0];
  assign gate_lvl = pin_s2_q[9:5];

  // ======================================================================
  // Registers
  logic [31:0] a_ctrl_q, a_ctrl_d;
  logic [15:0] a_cnt_q, a_cnt_d;
  logic [31:0] b_ctrl_q [4];
  logic [31:0] b_ctrl_d [4];
  logic [15:0] b_cnt_q [4];
  logic [15:0] b_cnt_d [4];
  timer_pkg::wr_state_t wr_st_q, wr_st_d;
  logic [15:0] wr_data_q, wr_data_d;
  logic [2:0] wr_edges_q, wr_edges_d;
  logic [31:0] rdata_d;
  logic pslverr_d;

  function automatic logic [31:0] b_mask(input int idx);
    b_mask = (idx % 2 == 0) ? `MASK_B_CTRL_EVEN : `MASK_B_CTRL_ODD;
  endfunction

  function automatic timer_pkg::tmr_cfg_t cfg_of(input logic [31:0] c);
    cfg_of.enable = c[`BIT_ENABLE];
    cfg_of.gate = c[`BIT_GATE];
    cfg_of.ext = c[`BIT_CLKSRC];
    cfg_of.ps = c[`BIT_PS_LO +: 3];
  endfunction

  logic wr_en;
  logic rd_en;
  logic addr_ok;
  assign wr_en = PSEL && PENABLE && PWRITE;
  assign rd_en = PSEL && PENABLE && !PWRITE;

  // ======================================================================
  // Type A asynchronous count write: the value is transferred on external
  // edges, so the pending bit covers the time that takes.
  logic a_async;
  logic a_wr_hit;
  logic a_wr_take;
  assign a_async = a_ctrl_q[`BIT_CLKSRC] && !a_ctrl_q[`BIT_SYNC];
  assign a_wr_hit = wr_en && PADDR == `ADDR_A_COUNT;
  assign a_wr_take = a_wr_hit &&
                     !(a_ctrl_q[`BIT_WBLOCK] && wr_st_q == timer_pkg::WR_WAIT);

  // ======================================================================
  // Timer tick generation
  timer_pkg::tmr_cfg_t cfg [5];
  logic [4:0] run;
  logic [4:0] src_evt;
  logic [4:0] tick;
  logic [3:0] log2_div [5];
  logic [4:0] cnt_en;
  logic wide [4];

  always_comb
  begin
    wide[0] = b_ctrl_q[0][`BIT_WIDE];
    wide[1] = 1'b0;
    wide[2] = b_ctrl_q[2][`BIT_WIDE];
    wide[3] = 1'b0;
    cfg[0] = cfg_of(a_ctrl_q);
    for (int i = 0; i < 4; i++)
    begin
      // Odd timer of a wide pair follows its even partner.
      cfg[i + 1] = cfg_of(b_ctrl_q[(i % 2 == 1 && wide[i - i % 2]) ? i - 1 : i]);
    end
    for (int i = 0; i < 5; i++)
    begin
      // Idle-stop of an odd wide timer is its own bit, so software clears it too.
      run[i] = cfg[i].enable && !(idle_q && (i == 0 ? a_ctrl_q[`BIT_IDLE_STOP] :
               b_ctrl_q[(i == 0) ? 0 : i - 1][`BIT_IDLE_STOP]));
      src_evt[i] = cfg[i].ext ? ext_rise[i] : 1'b1;
      cnt_en[i] = tick[i] && (cfg[i].ext || !cfg[i].gate || gate_lvl[i]);
    end
    case (cfg[0].ps[1:0])
      2'b00: log2_div[0] = 4'h0;
      2'b01: log2_div[0] = 4'h3;
      2'b10: log2_div[0] = 4'h6;
      default: log2_div[0] = 4'h8;
    endcase
    for (int i = 1; i < 5; i++)
    begin
      log2_div[i] = (cfg[i].ps == 3'h7) ? 4'h8 : {1'b0, cfg[i].ps};
    end
  end

  for (genvar g = 0; g < 5; g++)
  begin : g_ps
    timer_prescale u_ps (
      .clk(CORE_CLK),
      .rst_n(RSTN),
      .run(run[g]),
      .event_in(src_evt[g]),
      .log2_div(log2_div[g]),
      .tick(tick[g])
    );
  end

  // ======================================================================
  // Next-state logic for registers and counters
  always_comb
  begin
    a_ctrl_d = a_ctrl_q;
    a_cnt_d = a_cnt_q;
    wr_st_d = wr_st_q;
    wr_data_d = wr_data_q;
    wr_edges_d = wr_edges_q;
    for (int i = 0; i < 4; i++)
    begin
      b_ctrl_d[i] = b_ctrl_q[i];
      b_cnt_d[i] = b_cnt_q[i];
    end
    addr_ok = 1'b1;
    rdata_d = 32'h0000_0000;

    if (cnt_en[0] && run[0])
      a_cnt_d = a_cnt_q + 16'h0001;
    for (int i = 0; i < 4; i += 2)
    begin
      if (wide[i])
      begin
        // The odd timer's idle-stop bit still halts the whole pair in Idle mode.
        if (cnt_en[i + 1] && run[i + 1] && !(idle_q && b_ctrl_q[i + 1][`BIT_IDLE_STOP]))
          {b_cnt_d[i + 1], b_cnt_d[i]} = {b_cnt_q[i + 1], b_cnt_q[i]} + 32'h0000_0001;
      end
      else
      begin
        if (cnt_en[i + 1] && run[i + 1])
          b_cnt_d[i] = b_cnt_q[i] + 16'h0001;
        if (cnt_en[i + 2] && run[i + 2])
          b_cnt_d[i + 1] = b_cnt_q[i + 1] + 16'h0001;
      end
    end

    case (wr_st_q)
      timer_pkg::WR_IDLE:
        ;
      timer_pkg::WR_WAIT:
      begin
        if (ext_rise[0])
        begin
          if (wr_edges_q == `ASYNC_WRITE_EDGES - 3'h1)
          begin
            a_cnt_d = wr_data_q;
            wr_st_d = timer_pkg::WR_IDLE;
          end
          else
            wr_edges_d = wr_edges_q + 3'h1;
        end
      end
      default:
        wr_st_d = timer_pkg::WR_IDLE;
    endcase

    if (a_wr_take)
    begin
      if (a_async)
      begin
        wr_st_d = timer_pkg::WR_WAIT;
        wr_data_d = PWDATA[15:0];
        wr_edges_d = 3'h0;
      end
      else
        a_cnt_d = PWDATA[15:0];
    end

    if (PADDR == `ADDR_A_CTRL)
    begin
      if (wr_en)
        a_ctrl_d = PWDATA & `MASK_A_CTRL;
      rdata_d = a_ctrl_q & `MASK_A_CTRL;
      rdata_d[`BIT_WPEND] = a_async && wr_st_q == timer_pkg::WR_WAIT;
    end
    else if (PADDR == `ADDR_A_COUNT)
      rdata_d = {16'h0000, a_cnt_q};
    else if (PADDR >= `ADDR_B_CTRL0 && PADDR < `ADDR_B_CTRL0 + 12'h010 && PADDR[1:0] == 2'b00)
    begin
      for (int i = 0; i < 4; i++)
        if (PADDR[3:2] == 2'(i))
        begin
          if (wr_en)
            b_ctrl_d[i] = PWDATA & b_mask(i);
          rdata_d = b_ctrl_q[i] & b_mask(i);
          if (b_ctrl_q[i][`BIT_CLKSRC])
            rdata_d[`BIT_GATE] = 1'b0;
        end
    end
    else if (PADDR >= `ADDR_B_COUNT0 && PADDR < `ADDR_B_COUNT0 + 12'h010 && PADDR[1:0] == 2'b00)
    begin
      for (int i = 0; i < 4; i++)
        if (PADDR[3:2] == 2'(i))
        begin
          if (wr_en)
            b_cnt_d[i] = PWDATA[15:0];
          rdata_d = {16'h0000, b_cnt_q[i]};
        end
    end
    else
      addr_ok = 1'b0;

    pslverr_d = PSEL && !PENABLE && !addr_ok;
  end

  always_ff @(posedge CORE_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      a_ctrl_q <= `RESET_CTRL;
      a_cnt_q <= 16'h0000;
      wr_st_q <= timer_pkg::WR_IDLE;
      wr_data_q <= 16'h0000;
      wr_edges_q <= 3'h0;
      for (int i = 0; i < 4; i++)
      begin
        b_ctrl_q[i] <= `RESET_CTRL;
        b_cnt_q[i] <= 16'h0000;
      end
      PRDATA <= 32'h0000_0000;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end
    else
    begin
      a_ctrl_q <= a_ctrl_d;
      a_cnt_q <= a_cnt_d;
      wr_st_q <= wr_st_d;
      wr_data_q <= wr_data_d;
      wr_edges_q <= wr_edges_d;
      for (int i = 0; i < 4; i++)
      begin
        b_ctrl_q[i] <= b_ctrl_d[i];
        b_cnt_q[i] <= b_cnt_d[i];
      end
      // Read data is captured in the setup cycle so it is ready in the access cycle.
      if (PSEL && !PENABLE)
        PRDATA <= rdata_d;
      PREADY <= PSEL && !PENABLE;
      PSLVERR <= pslverr_d;
    end
  end

endmodule

// ==== test/timer_block_assertions.sv ====
`timescale 1ns/1ps
`include "timer_cfg.svh"
// ==========
// Bus and readback checks
module timer_block_checker (
  input wire logic CORE_CLK,
  input wire logic RSTN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);
  wire rd_ok = PREADY && !PWRITE;
  wire b_reg = PADDR[11:4] == 8'h01;
  AST_ANSWER: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("ready missing");
  AST_ONE_CYCLE: assert property (PREADY |=> !PREADY)
    else $error("ready too long");
  AST_HIGH_ZERO: assert property (
    rd_ok |-> PRDATA[31:16] == 16'h0000) else $error("upper bits set");
  AST_A_BITS: assert property (
    rd_ok && PADDR == `ADDR_A_CTRL |-> (PRDATA & ~(`MASK_A_CTRL | 32'h0800)) == 32'h0)
    else $error("reserved bit set");
  AST_ODD_NO_WIDE: assert property (
    rd_ok && b_reg && PADDR[2] |-> (PRDATA & ~`MASK_B_CTRL_ODD) == 32'h0)
    else $error("odd wide bit");
  AST_B_GATE_EXT: assert property (
    rd_ok && b_reg && PRDATA[1] |-> !PRDATA[7]) else $error("gate bit read");
  AST_SYNC_NO_PEND: assert property (
    rd_ok && PADDR == `ADDR_A_CTRL && !PRDATA[1] |-> !PRDATA[11])
    else $error("pending in sync mode");
  AST_UNMAPPED: assert property (
    PSEL && !PENABLE && PADDR[11:8] != 4'h0 |=> PSLVERR && PRDATA == 32'h0)
    else $error("unmapped accepted");
endmodule
bind timer_block timer_block_checker u_chk (.CORE_CLK(CORE_CLK), .RSTN(RSTN), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR));

// ==== test/ext_pins.sv ====
`timescale 1ns/1ps
// ==========
// External clock and gate pins
module ext_pins (
  input wire logic clk,
  input wire logic run,
  input wire logic gate,
  output logic a_clk,
  output logic [3:0] b_clk,
  output logic a_gate,
  output logic [3:0] b_gate
);
  logic [3:0] div_q = 4'h0;
  // The pin clock stands still while run is low, so counts follow run time.
  always @(posedge clk)
    if (run)
      div_q <= div_q + 4'h1;
  assign a_clk = div_q[3];
  assign b_clk = {4{div_q[3]}};
  assign a_gate = gate;
  assign b_gate = {4{gate}};
endmodule

// ==== test/test_timer_control_type_a_b.sv ====
`timescale 1ns/1ps
`include "timer_cfg.svh"
// ==========
// Bench
module test_timer_control_type_a_b;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic idle = 1'b0;
  logic run = 1'b0;
  logic gate = 1'b1;
  logic a_clk;
  logic a_gate;
  logic [3:0] b_clk;
  logic [3:0] b_gate;
  logic [31:0] rd;
  logic err;
  logic [31:0] seed = 32'd3986;
  logic [31:0] e;
  logic [31:0] exp_q[$];
  int n_errors = 0;
  int checked = 0;
  int dv[12] = '{1, 8, 64, 256, 1, 2, 4, 8, 16, 32, 64, 256};
  logic [11:0] ca[5] = '{12'h000, 12'h010, 12'h014, 12'h018, 12'h01C};
  always #4 clk = ~clk;
  timer_block u_dut (.CORE_CLK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .IDLE_MODE(idle), .TYPE_A_EXT_CLOCK_PIN(a_clk),
    .TYPE_A_GATE_PIN(a_gate), .TYPE_B_EXT_CLOCK_PIN(b_clk), .TYPE_B_GATE_PIN(b_gate));
  ext_pins u_pins (.clk(clk), .run(run), .gate(gate), .a_clk(a_clk), .b_clk(b_clk),
    .a_gate(a_gate), .b_gate(b_gate));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic finish_test;
    $display("errors %0d checked %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    checked++;
    if (s !== x)
    begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, x);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      n_errors++;
      finish_test();
    end
    @(posedge clk); // The idle cycle keeps the bus quiet after an enable clears.
  endtask
  // Counts for 512 enabled cycles; sync and prescaler latency leave a small window.
  task automatic run_for(input logic [11:0] c, k, input logic [31:0] p, v, input int x);
    apb(1'b1, k, p);
    apb(1'b1, c, v);
    repeat (509) @(posedge clk);
    apb(1'b1, c, 32'h0);
    apb(1'b0, k, 32'h0);
    chk({31'h0, (rd & 32'hFFFF) + 32'd3 >= x && (rd & 32'hFFFF) <= x + 1}, 32'h1);
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b0, ca[i], 32'h0);
      chk(rd, 32'h0);
      repeat (32) seed = lfsr(seed);
      apb(1'b1, ca[i], seed);
      apb(1'b0, ca[i], 32'h0);
      e = seed & (i == 0 ? `MASK_A_CTRL : i[0] ? `MASK_B_CTRL_EVEN : `MASK_B_CTRL_ODD);
      if (i > 0 && e[1])
        e[7] = 1'b0;
      exp_q.push_back(e);
      chk(rd, exp_q.pop_front());
      apb(1'b1, ca[i], 32'h0);
    end
    apb(1'b0, 12'h100, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, err}, 32'h1);
    for (int i = 0; i < 12; i++)
      run_for(i < 4 ? 12'h000 : 12'h010, i < 4 ? 12'h004 : 12'h020, 32'h0,
        32'h8000 | (i < 4 ? i : i - 4) << 4, 512 / dv[i]);
    gate <= 1'b0;
    run_for(12'h014, 12'h024, 32'h0, 32'h8080, 0);
    gate <= 1'b1;
    run_for(12'h014, 12'h024, 32'h0, 32'h8080, 512);
    idle <= 1'b1;
    run_for(12'h014, 12'h024, 32'h0, 32'hA000, 0);
    run_for(12'h014, 12'h024, 32'h0, 32'h8000, 512);
    idle <= 1'b0;
    run <= 1'b1;
    gate <= 1'b0;
    run_for(12'h01C, 12'h02C, 32'h0, 32'h8082, 32);
    gate <= 1'b1;
    idle <= 1'b1;
    apb(1'b1, 12'h01C, 32'h2072);
    run_for(12'h018, 12'h028, 32'h0, 32'h8008, 0); // Odd idle stop halts the pair.
    apb(1'b1, 12'h01C, 32'h0072); // Odd half left with idle stop clear.
    apb(1'b1, 12'h02C, 32'h0);
    run_for(12'h018, 12'h028, 32'hFFF0, 32'h8008, 32'h1F0);
    apb(1'b0, 12'h02C, 32'h0);
    chk(rd, 32'h1);
    idle <= 1'b0;
    run <= 1'b0;
    apb(1'b1, 12'h000, 32'h9032);
    apb(1'b1, 12'h004, 32'h55);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h9832);
    apb(1'b1, 12'h004, 32'h77);
    run <= 1'b1;
    repeat (64) @(posedge clk);
    run <= 1'b0;
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h55);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h9032);
    finish_test();
  end
endmodule
